// File: common/sgcr_pkg.sv
package sgcr_pkg;

	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	localparam int NUM_PORTS = 5;
	localparam int STORM_W = 11;
	localparam int STORM_HI_W = 3;
	localparam int STORM_LO_W = 8;

	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_VLAN_CTRL = 4'h5;
	localparam logic [3:0] IDX_UPLINK_MODE = 4'h6;
	localparam logic [3:0] IDX_STORM_LOW = 4'h7;
	localparam logic [3:0] IDX_STAT_CTRL = 4'h8;
	localparam logic [APB_AW-1:0] ADDR_VLAN_CTRL = {2'h0, IDX_VLAN_CTRL, 2'h0};
	localparam logic [APB_AW-1:0] ADDR_UPLINK_MODE = {2'h0, IDX_UPLINK_MODE, 2'h0};
	localparam logic [APB_AW-1:0] ADDR_STORM_LOW = {2'h0, IDX_STORM_LOW, 2'h0};
	localparam logic [APB_AW-1:0] ADDR_STAT_CTRL = {2'h0, IDX_STAT_CTRL, 2'h0};

	// vlan_igmp_sniff_control
	localparam int B_VLAN_EN = 7;
	localparam int B_IGMP_SNOOP = 6;
	localparam int B_SNIFF_AND = 0;
	// uplink_mode_storm_high
	localparam int B_BP_EN = 7;
	localparam int B_HALF_DUPLEX = 6;
	localparam int B_FLOW_CTRL = 5;
	localparam int B_SPEED10 = 4;
	localparam int B_NULL_VID_SUB = 3;
	localparam int B_STORM_HI = 0;
	// storm_rate_low
	localparam int B_STORM_LO = 0;
	// stat_counter_control
	localparam int B_FLUSH = 7;
	localparam int B_FREEZE = 6;
	localparam int B_PORT_EN = 0;

	localparam logic [STORM_HI_W-1:0] RST_STORM_HI = 3'h0;
	localparam logic [STORM_LO_W-1:0] RST_STORM_LO = 8'h4a;
	localparam logic [NUM_PORTS-1:0] RST_PORT_EN = 5'h00;

	// storm measurement period
	localparam int CLK_HZ = 40_000_000;
	localparam int STORM_FAST_MS = 50;
	localparam int STORM_SLOW_MS = 500;
	localparam int STORM_FAST_CYCLES_DEF = (CLK_HZ / 1000) * STORM_FAST_MS;
	localparam int STORM_SLOW_RATIO = STORM_SLOW_MS / STORM_FAST_MS;

	typedef struct packed {
		logic vlan_en;
		logic igmp_snoop;
		logic sniff_and;
		logic bp_en;
		logic half_duplex;
		logic flow_ctrl;
		logic speed10;
		logic null_vid_sub;
		logic [STORM_W-1:0] storm_limit;
	} sgcr_ctrl_s;

	localparam sgcr_ctrl_s CTRL_RST = '{
		vlan_en: 1'b0,
		igmp_snoop: 1'b0,
		sniff_and: 1'b0,
		bp_en: 1'b0,
		half_duplex: 1'b0,
		flow_ctrl: 1'b0,
		speed10: 1'b0,
		null_vid_sub: 1'b0,
		storm_limit: {RST_STORM_HI, RST_STORM_LO}
	};

	typedef struct packed {
		logic [NUM_PORTS-1:0] flush_req;
		logic [NUM_PORTS-1:0] freeze;
	} sgcr_mib_s;

endpackage : sgcr_pkg

// File: verilog/sgcr_storm_period.sv
module sgcr_storm_period
	import sgcr_pkg::*;
#(
	parameter int FAST_CYCLES = STORM_FAST_CYCLES_DEF,
	parameter int RATIO = STORM_SLOW_RATIO
)
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	output logic tick_fast_o,
	output logic tick_slow_o
);
	localparam int FW = $clog2(FAST_CYCLES);
	localparam int SW = $clog2(RATIO);

	if (FAST_CYCLES < 2 || RATIO < 2)
		$error("storm period counts must be at least two");

	logic [FW-1:0] fast_reg, fast_next;
	logic [SW-1:0] slow_reg, slow_next;
	logic tick_fast_reg, tick_fast_next;
	logic tick_slow_reg, tick_slow_next;

	always_comb
	begin
		fast_next = fast_reg + 1'b1;
		slow_next = slow_reg;
		tick_fast_next = 1'b0;
		tick_slow_next = 1'b0;
		if (fast_reg == FW'(FAST_CYCLES - 1))
		begin
			fast_next = '0;
			tick_fast_next = 1'b1;
			slow_next = slow_reg + 1'b1;
			if (slow_reg == SW'(RATIO - 1))
			begin
				slow_next = '0;
				tick_slow_next = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			fast_reg <= '0;
			slow_reg <= '0;
			tick_fast_reg <= 1'b0;
			tick_slow_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			fast_reg <= fast_next;
			slow_reg <= slow_next;
			tick_fast_reg <= tick_fast_next;
			tick_slow_reg <= tick_slow_next;
		end
	end

	assign tick_fast_o = tick_fast_reg;
	assign tick_slow_o = tick_slow_reg;

endmodule : sgcr_storm_period

// File: verilog/sgcr_mib_flush.sv
module sgcr_mib_flush
	import sgcr_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic [NUM_PORTS-1:0] port_en_i,
	input wire logic done_i,
	output logic busy_o,
	output logic [NUM_PORTS-1:0] req_o
);
	typedef enum logic {S_IDLE, S_BUSY} sgcr_flush_e;

	sgcr_flush_e state_reg, state_next;
	logic [NUM_PORTS-1:0] req_reg, req_next;

	always_comb
	begin
		state_next = state_reg;
		req_next = req_reg;
		unique case (state_reg)
			S_IDLE:
			begin
				if (start_i)
				begin
					state_next = S_BUSY;
					req_next = port_en_i;
				end
			end
			S_BUSY:
			begin
				// a new start wins over done and reissues the flush with fresh enables
				if (start_i)
					req_next = port_en_i;
				else if (done_i || req_reg == '0)
				begin
					state_next = S_IDLE;
					req_next = '0;
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			state_reg <= S_IDLE;
			req_reg <= '0;
		end
		else if (ce_i)
		begin
			state_reg <= state_next;
			req_reg <= req_next;
		end
	end

	assign busy_o = (state_reg == S_BUSY);
	assign req_o = req_reg;

endmodule : sgcr_mib_flush

// File: verilog/sgcr_top.sv
// Behaviour
// - control bit 7 at 0x05 turns 802.1q vlan mode on or off.
// - bit 6 at 0x05 sends all igmp packets to the uplink port.
// - sniff mode bit set needs both ports matching, clear needs either.
// - bit 7 at 0x06 enables half-duplex back pressure on the uplink.
// - bit 6 at 0x06 selects uplink half duplex, clear full duplex.
// - bit 5 at 0x06 enables uplink full-duplex flow control.
// - bit 4 at 0x06 selects uplink 10 Mbps, clear 100 Mbps.
// - bit 3 at 0x06 replaces empty vlan id with port default id.
// - storm limit is 11 bits, 0x06[2:0] high, 0x07 low, in 64-byte blocks.
// - storm period is 50 ms at 100 Mbps, 500 ms at 10 Mbps.
// - storm limit resets to low byte 0x4a, upper three bits zero.
// - writing one to bit 7 at 0x08 flushes counters of enabled ports.
// - flush bit clears itself when the flush completes.
// - bit 6 at 0x08 freezes counters of enabled ports while set.
// - bits 4..0 at 0x08 enable flush and freeze for ports 5..1.
module sgcr_top
	import sgcr_pkg::*;
#(
	parameter int STORM_FAST_CYCLES = STORM_FAST_CYCLES_DEF
)
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [APB_AW-1:0] paddr_i,
	input wire logic [APB_DW-1:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [APB_DW-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output sgcr_ctrl_s ctrl_o,
	output sgcr_mib_s mib_o,
	input wire logic mib_flush_done_i,
	input wire logic [NUM_PORTS-2:0] port_speed10_i,
	input wire logic [NUM_PORTS-1:0] storm_block_i,
	output logic [NUM_PORTS-1:0] storm_over_o
);
	if (STORM_FAST_CYCLES < 2)
		$error("storm period must span at least two cycles");

	// every register field lives in byte lane 0
	if (STORM_HI_W + STORM_LO_W != STORM_W)
		$error("storm limit halves must make up the full width");
	if (NUM_PORTS < 2 || NUM_PORTS > B_FREEZE - B_PORT_EN)
		$error("port enables must fit below the freeze bit");
	if (B_STORM_HI + STORM_HI_W > B_NULL_VID_SUB)
		$error("storm high bits overlap the replacement bit");

	function automatic logic addr_hit(input logic [APB_AW-1:0] a);
		addr_hit = (a == ADDR_VLAN_CTRL) || (a == ADDR_UPLINK_MODE) ||
			(a == ADDR_STORM_LOW) || (a == ADDR_STAT_CTRL);
	endfunction : addr_hit

	// reserved positions stay zero, their default
	function automatic logic [APB_DW-1:0] rd_word(
		input logic [APB_AW-1:0] a,
		input sgcr_ctrl_s c,
		input logic flush,
		input logic freeze,
		input logic [NUM_PORTS-1:0] en
	);
		logic [APB_DW-1:0] w;
		w = '0;
		unique case (a)
			ADDR_VLAN_CTRL:
			begin
				w[B_VLAN_EN] = c.vlan_en;
				w[B_IGMP_SNOOP] = c.igmp_snoop;
				w[B_SNIFF_AND] = c.sniff_and;
			end
			ADDR_UPLINK_MODE:
			begin
				w[B_BP_EN] = c.bp_en;
				w[B_HALF_DUPLEX] = c.half_duplex;
				w[B_FLOW_CTRL] = c.flow_ctrl;
				w[B_SPEED10] = c.speed10;
				w[B_NULL_VID_SUB] = c.null_vid_sub;
				w[B_STORM_HI +: STORM_HI_W] = c.storm_limit[STORM_W-1 -: STORM_HI_W];
			end
			ADDR_STORM_LOW:
				w[B_STORM_LO +: STORM_LO_W] = c.storm_limit[STORM_LO_W-1:0];
			ADDR_STAT_CTRL:
			begin
				w[B_FLUSH] = flush;
				w[B_FREEZE] = freeze;
				w[B_PORT_EN +: NUM_PORTS] = en;
			end
			default:
				w = '0;
		endcase
		rd_word = w;
	endfunction : rd_word

	// ---------------- apb slave ----------------
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [APB_DW-1:0] prdata_reg, prdata_next;
	logic wr_commit;
	logic flush_busy;
	logic [NUM_PORTS-1:0] flush_req;

	// control registers
	sgcr_ctrl_s ctrl_reg, ctrl_next;
	logic freeze_reg, freeze_next;
	logic [NUM_PORTS-1:0] port_en_reg, port_en_next;
	logic [NUM_PORTS-1:0] mib_freeze_reg, mib_freeze_next;
	logic flush_start;

	// one wait state so read data and error come from flops
	always_comb
	begin
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		prdata_next = '0;
		// an access held past its answer is not answered again in the cycle right after it
		if (psel_i && penable_i && !pready_reg)
		begin
			pready_next = 1'b1;
			pslverr_next = !addr_hit(paddr_i);
			if (!pwrite_i)
				prdata_next = rd_word(paddr_i, ctrl_reg, flush_busy, freeze_reg, port_en_reg);
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end
		else if (ce_i)
		begin
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	// writes land only at the completing edge; byte lane 0 carries all fields
	assign wr_commit = psel_i && penable_i && pready_reg && pwrite_i && pstrb_i[0];

	always_comb
	begin
		ctrl_next = ctrl_reg;
		freeze_next = freeze_reg;
		port_en_next = port_en_reg;
		flush_start = 1'b0;
		if (wr_commit)
		begin
			unique case (paddr_i)
				ADDR_VLAN_CTRL:
				begin
					ctrl_next.vlan_en = pwdata_i[B_VLAN_EN];
					ctrl_next.igmp_snoop = pwdata_i[B_IGMP_SNOOP];
					ctrl_next.sniff_and = pwdata_i[B_SNIFF_AND];
				end
				ADDR_UPLINK_MODE:
				begin
					ctrl_next.bp_en = pwdata_i[B_BP_EN];
					ctrl_next.half_duplex = pwdata_i[B_HALF_DUPLEX];
					ctrl_next.flow_ctrl = pwdata_i[B_FLOW_CTRL];
					ctrl_next.speed10 = pwdata_i[B_SPEED10];
					ctrl_next.null_vid_sub = pwdata_i[B_NULL_VID_SUB];
					ctrl_next.storm_limit[STORM_W-1 -: STORM_HI_W] =
						pwdata_i[B_STORM_HI +: STORM_HI_W];
				end
				ADDR_STORM_LOW:
					ctrl_next.storm_limit[STORM_LO_W-1:0] = pwdata_i[B_STORM_LO +: STORM_LO_W];
				ADDR_STAT_CTRL:
				begin
					flush_start = pwdata_i[B_FLUSH];
					freeze_next = pwdata_i[B_FREEZE];
					port_en_next = pwdata_i[B_PORT_EN +: NUM_PORTS];
				end
				default:
					ctrl_next = ctrl_reg;
			endcase
		end
		// freeze reaches only the enabled ports
		mib_freeze_next = freeze_next ? port_en_next : '0;
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			ctrl_reg <= CTRL_RST;
			freeze_reg <= 1'b0;
			port_en_reg <= RST_PORT_EN;
			mib_freeze_reg <= '0;
		end
		else if (ce_i)
		begin
			ctrl_reg <= ctrl_next;
			freeze_reg <= freeze_next;
			port_en_reg <= port_en_next;
			mib_freeze_reg <= mib_freeze_next;
		end
	end

	// flush uses the enables as written in the same access
	// done comes from the counter block on this clock, so it needs no synchroniser
	sgcr_mib_flush u_flush (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.start_i(flush_start),
		.port_en_i(port_en_next),
		.done_i(mib_flush_done_i),
		.busy_o(flush_busy),
		.req_o(flush_req)
	);

	// ---------------- broadcast storm admission ----------------
	logic tick_fast;
	logic tick_slow;
	logic [STORM_W-1:0] storm_cnt_reg [NUM_PORTS];
	logic [STORM_W-1:0] storm_cnt_next [NUM_PORTS];
	logic [NUM_PORTS-1:0] storm_over_reg, storm_over_next;
	logic [NUM_PORTS-1:0] speed10_vec;

	sgcr_storm_period #(
		.FAST_CYCLES(STORM_FAST_CYCLES),
		.RATIO(STORM_SLOW_RATIO)
	) u_period (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tick_fast_o(tick_fast),
		.tick_slow_o(tick_slow)
	);

	// the uplink takes its speed from the register, the others from their mac
	assign speed10_vec = {ctrl_reg.speed10, port_speed10_i};

	// counting stops at the limit, so a count never wraps inside a period
	always_comb
	begin
		logic slow;
		logic tick;
		logic [STORM_W-1:0] base;
		logic over;
		slow = 1'b0;
		tick = 1'b0;
		base = '0;
		over = 1'b0;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			slow = speed10_vec[p];
			tick = slow ? tick_slow : tick_fast;
			base = tick ? '0 : storm_cnt_reg[p];
			over = tick ? 1'b0 : storm_over_reg[p];
			// a block arriving on the period edge counts in the new period
			if (storm_block_i[p])
			begin
				if (base >= ctrl_reg.storm_limit)
					over = 1'b1;
				else
					base = base + 1'b1;
			end
			storm_cnt_next[p] = base;
			storm_over_next[p] = over;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
				storm_cnt_reg[p] <= '0;
			storm_over_reg <= '0;
		end
		else if (ce_i)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
				storm_cnt_reg[p] <= storm_cnt_next[p];
			storm_over_reg <= storm_over_next;
		end
	end

	// ---------------- outputs ----------------
	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign ctrl_o = ctrl_reg;
	assign mib_o = '{flush_req: flush_req, freeze: mib_freeze_reg};
	assign storm_over_o = storm_over_reg;

endmodule : sgcr_top

// File: dv/sgcr_top_monitor.sv
module sgcr_top_monitor
	import sgcr_pkg::*;
#(
	parameter int STORM_FAST_CYCLES = STORM_FAST_CYCLES_DEF
)
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [APB_AW-1:0] paddr_i,
	input wire logic [APB_DW-1:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [APB_DW-1:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire sgcr_ctrl_s ctrl_o,
	input wire sgcr_mib_s mib_o,
	input wire logic mib_flush_done_i
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	sequence acc_s;
		psel_i && penable_i && pready_o && ce_i;
	endsequence
	sequence wr_s(a);
		acc_s ##0 (pwrite_i && pstrb_i[0] && paddr_i == a);
	endsequence

	chk_ready_wait: assert property (psel_i && penable_i && !pready_o && ce_i |=> pready_o)
		else $error("access not answered after one wait state");
	chk_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == '0)
		else $error("error response without ready or with data");
	// packed order puts vlan, igmp, sniff at 18:16 and the uplink byte at 15:8
	chk_vlan_write: assert property (wr_s(ADDR_VLAN_CTRL) |=>
		ctrl_o[18:16] == {$past(pwdata_i[7]), $past(pwdata_i[6]), $past(pwdata_i[0])})
		else $error("vlan control outputs do not follow write");
	chk_uplink_write: assert property (wr_s(ADDR_UPLINK_MODE) |=> ctrl_o[15:8] == $past(pwdata_i[7:0]))
		else $error("uplink mode outputs do not follow write");
	chk_storm_low: assert property (wr_s(ADDR_STORM_LOW) |=> ctrl_o[7:0] == $past(pwdata_i[7:0]))
		else $error("storm limit low byte does not follow write");
	chk_freeze_map: assert property (wr_s(ADDR_STAT_CTRL) |=>
		mib_o.freeze == ({NUM_PORTS{$past(pwdata_i[6])}} & $past(pwdata_i[4:0])))
		else $error("freeze outputs wrong after write");
	chk_flush_start: assert property (wr_s(ADDR_STAT_CTRL) ##0 pwdata_i[7] |=>
		mib_o.flush_req == $past(pwdata_i[4:0]))
		else $error("flush request does not follow enables");
	chk_flush_done: assert property (mib_flush_done_i && ce_i &&
		!(psel_i && penable_i && pready_o && pwrite_i) |=>
		mib_o.flush_req == '0)
		else $error("flush request not cleared by done");
	chk_ctrl_hold: assert property (!(psel_i && penable_i && pwrite_i) |=> $stable(ctrl_o))
		else $error("control outputs changed without a write");
endmodule : sgcr_top_monitor

bind sgcr_top sgcr_top_monitor #(.STORM_FAST_CYCLES(STORM_FAST_CYCLES)) u_mon (.mclk_i(mclk_i), .rst_i(rst_i),
	.ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.ctrl_o(ctrl_o), .mib_o(mib_o), .mib_flush_done_i(mib_flush_done_i));

// File: dv/sgcr_top_tb.sv
module sgcr_top_tb
	import sgcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk = 1'b0;
	logic ce = 1'b1;
	logic rst = 1'b1;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, fdone = 1'b0, prdy, perr, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic [3:0] spd10 = 4'h0;
	logic [4:0] blk = 5'h00, over;
	logic [7:0] pat [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
	sgcr_ctrl_s ctrl;
	sgcr_mib_s mib;
	int err_total = 0, total_checks = 0, n;

	always #12.5 mclk = ~mclk;

	// short storm period keeps the slow period at 200 cycles
	sgcr_top #(.STORM_FAST_CYCLES(20)) dut (.mclk_i(mclk), .rst_i(rst), .ce_i(ce), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr), .ctrl_o(ctrl), .mib_o(mib),
		.mib_flush_done_i(fdone), .port_speed10_i(spd10), .storm_block_i(blk), .storm_over_o(over));

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		pen <= 1'b1;
		// only the watchdog ends a wait for the answer
		do
			@(posedge mclk);
		while (prdy !== 1'b1);
		rd = prdata;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask : rdchk

	task automatic blocks(input logic [4:0] m, input int c);
		repeat (c)
		begin
			blk <= m;
			@(posedge mclk);
		end
		blk <= 5'h00;
		@(posedge mclk);
	endtask : blocks

	// leaves port p over its limit with no blocks pending, so the next clear is a period edge
	task automatic flood(input logic [4:0] m, input int p);
		do
		begin
			blk <= m;
			do
				@(posedge mclk);
			while (over[p] !== 1'b1);
			blk <= 5'h00;
			repeat (2) @(posedge mclk);
		end
		while (over[p] !== 1'b1);
	endtask : flood

	task automatic settle(input int p);
		n = 0;
		while (over[p] !== 1'b0 && n < 250)
		begin
			@(posedge mclk);
			n++;
		end
	endtask : settle

	initial
	begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk("ctrl reset", 32'(ctrl), 32'h4a);
		rdchk("reg05", ADDR_VLAN_CTRL, 32'h0);
		rdchk("reg06", ADDR_UPLINK_MODE, 32'h0);
		rdchk("reg07", ADDR_STORM_LOW, 32'h4a);
		rdchk("reg08", ADDR_STAT_CTRL, 32'h0);
		foreach (pat[i])
		begin
			apb(1'b1, ADDR_VLAN_CTRL, {24'h0, pat[i]});
			rdchk("reg05", ADDR_VLAN_CTRL, {24'h0, pat[i] & 8'hc1});
			chk("vlan ctrl", 32'(ctrl[18:16]), {29'h0, pat[i][7:6], pat[i][0]});
			apb(1'b1, ADDR_UPLINK_MODE, {24'h0, pat[i]});
			rdchk("reg06", ADDR_UPLINK_MODE, {24'h0, pat[i]});
			chk("uplink ctrl", 32'(ctrl[15:8]), {24'h0, pat[i]});
		end
		pstrb <= 4'h0;
		apb(1'b1, ADDR_STORM_LOW, 32'h33);
		pstrb <= 4'hf;
		rdchk("strobe off", ADDR_STORM_LOW, 32'h4a);
		apb(1'b1, ADDR_STORM_LOW, 32'h12);
		chk("storm limit", 32'(ctrl.storm_limit), 32'h12);
		apb(1'b0, 8'h24, 32'h0);
		chk("unmapped err", 32'(e), 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, ADDR_STAT_CTRL, 32'h7f);
		rdchk("reg08 rsv", ADDR_STAT_CTRL, 32'h5f);
		chk("freeze all", 32'(mib.freeze), 32'h1f);
		apb(1'b1, ADDR_STAT_CTRL, 32'h55);
		chk("freeze some", 32'(mib.freeze), 32'h15);
		apb(1'b1, ADDR_STAT_CTRL, 32'h8a);
		chk("freeze off", 32'(mib.freeze), 32'h0);
		chk("flush req", 32'(mib.flush_req), 32'h0a);
		rdchk("flush busy", ADDR_STAT_CTRL, 32'h8a);
		fdone <= 1'b1;
		@(posedge mclk);
		fdone <= 1'b0;
		@(posedge mclk);
		chk("flush end", 32'(mib.flush_req), 32'h0);
		rdchk("flush clear", ADDR_STAT_CTRL, 32'h0a);
		// the vlan table sits outside this block and counts as filled before this write
		ce <= 1'b0;
		fork
			apb(1'b1, ADDR_VLAN_CTRL, 32'h80);
			begin
				repeat (4) @(posedge mclk);
				chk("ce freeze", {31'h0, ctrl.vlan_en}, 32'h0);
				chk("ce no answer", {31'h0, prdy}, 32'h0);
				ce <= 1'b1;
			end
		join
		chk("vlan on", {31'h0, ctrl.vlan_en}, 32'h1);
		apb(1'b1, ADDR_STORM_LOW, 32'h2);
		spd10 <= 4'h2;
		flood(5'h01, 0);
		settle(0);
		blocks(5'h01, 2);
		chk("at limit", 32'(over[0]), 32'h0);
		blocks(5'h01, 1);
		chk("over limit", 32'(over[0]), 32'h1);
		settle(0);
		chk("fast period", 32'(n >= 10 && n <= 20), 32'h1);
		flood(5'h02, 1);
		settle(1);
		blocks(5'h02, 3);
		settle(1);
		chk("slow period", 32'(n >= 190 && n <= 200), 32'h1);
		apb(1'b1, ADDR_UPLINK_MODE, 32'h10);
		flood(5'h10, 4);
		settle(4);
		blocks(5'h10, 3);
		settle(4);
		chk("uplink slow", 32'(n >= 190 && n <= 200), 32'h1);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk("ctrl rereset", 32'(ctrl), 32'h4a);
		chk("mib rereset", 32'(mib), 32'h0);
		chk("over rereset", 32'(over), 32'h0);
		rdchk("reg07 rereset", ADDR_STORM_LOW, 32'h4a);
		report_and_stop();
	end

	initial
	begin
		#(25 * 5000);
		err_total++;
		report_and_stop();
	end
endmodule : sgcr_top_tb
